// file: include/pipe_timing_pkg.sv
package pipe_timing_pkg;

  // Core clock period; every time below is held in picoseconds.
  localparam int CLK_PERIOD_PS = 10000;
  localparam int SYNC_CYC = 2;

  localparam int TX_LAT_NOM_PS = 29200;
  localparam int TX_LAT_MAX_PS = 33200;
  localparam int RX_LAT_NOM_PS = 77200;
  localparam int RX_LAT_MAX_PS = 93200;
  localparam int LPBK_LAT_NOM_PS = 25200;
  localparam int LPBK_LAT_MAX_PS = 29200;
  localparam int LOCK_NOM_PS = 2000000;
  localparam int LOCK_MAX_PS = 4000000;
  localparam int PD_WAKE_NOM_PS = 28000;
  localparam int PD_WAKE_MAX_PS = 32000;
  localparam int RST_READY_NOM_PS = 10000;
  localparam int RST_READY_MAX_PS = 11000;

  function automatic int cyc_floor(input int ps);
    return (ps / CLK_PERIOD_PS < 1) ? 1 : ps / CLK_PERIOD_PS;
  endfunction : cyc_floor

  function automatic int cyc_ceil(input int ps);
    return ((ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS < 1) ? 1 :
           (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  endfunction : cyc_ceil

  function automatic int at_least_one(input int n);
    return (n < 1) ? 1 : n;
  endfunction : at_least_one

  // Cycle counts; the two pipe depths and the wake count are what is left after the input synchronisers take their share.
  localparam int TX_PIPE_CYC = at_least_one(cyc_floor(TX_LAT_MAX_PS) - SYNC_CYC);
  localparam int RX_PIPE_CYC = at_least_one(cyc_ceil(RX_LAT_NOM_PS) - SYNC_CYC);
  localparam int LOCK_NOM_CYC = cyc_ceil(LOCK_NOM_PS);
  localparam int LOCK_MAX_CYC = cyc_floor(LOCK_MAX_PS);
  localparam int PD_WAKE_CYC = at_least_one(cyc_floor(PD_WAKE_MAX_PS) - SYNC_CYC);
  localparam int RST_READY_CYC = cyc_floor(RST_READY_MAX_PS);

  localparam logic [7:0] N_FTS_COMMON = 8'h17;
  localparam logic [7:0] N_FTS_SEPARATE = 8'hff;

  localparam logic [1:0] PD_P0 = 2'h0;
  localparam logic [1:0] PD_P0S = 2'h1;
  localparam logic [1:0] PD_P1 = 2'h2;

  localparam logic [7:0] SYM_COMMA = 8'hbc;
  localparam logic [7:0] SYM_FAST_TRAIN = 8'h3c;

  // Symbol layout: bit 9 parity over bits 8..0, bit 8 control flag, bits 7..0 byte.
  localparam int SYM_PAR_BIT = 9;
  localparam int SYM_K_BIT = 8;

  typedef enum logic [1:0] {LK_IDLE, LK_TRAIN, LK_LOCKED} lock_state_e;

endpackage : pipe_timing_pkg

// file: rtl/sync_2ff.sv
module sync_2ff #(
  parameter int WIDTH = 1
) (
  // Clock and reset of the receiving domain
  input wire logic clk,
  input wire logic rst_n,
  // Level crossing
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_dout;

  // The first stage feeds only the second stage.
  always_comb begin
    next_meta = rst_n ? din : '0;
    next_dout = rst_n ? meta : '0;
  end

  always_ff @(posedge clk) begin
    meta <= next_meta;
    dout <= next_dout;
  end

endmodule : sync_2ff

// file: rtl/cycle_delay_line.sv
module cycle_delay_line #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Delayed data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage [DEPTH];
  logic [WIDTH-1:0] next_stage [DEPTH];

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      if (!rst_n) begin
        next_stage[i] = '0;
      end else if (i == 0) begin
        next_stage[i] = din;
      end else begin
        next_stage[i] = stage[i-1];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    stage <= next_stage;
  end

  assign dout = stage[DEPTH-1];

endmodule : cycle_delay_line

// file: rtl/pipe_phy_latency_power_timing.sv
module pipe_phy_latency_power_timing (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Parallel transmit side, clocked by the MAC
  input wire logic tx_clk,
  input wire logic [7:0] tx_data,
  input wire logic tx_data_valid,
  input wire logic tx_datak,
  output logic tx_ready,
  // Parallel receive side, clocked by this device
  output logic rx_clk,
  output logic [7:0] rx_data,
  output logic rx_datak,
  output logic rx_data_valid,
  output logic rx_decode_err,
  // Control from the MAC
  input wire logic [1:0] powerdown,
  input wire logic loopback_req,
  input wire logic common_clock,
  // Status to the MAC
  output logic phy_ready_indication,
  output logic rx_locked,
  output logic [7:0] n_fts_adv,
  // Serial side at symbol level
  output logic [9:0] ser_tx_sym,
  output logic ser_tx_sym_valid,
  input wire logic [9:0] ser_rx_sym,
  input wire logic ser_rx_sym_valid
);

  function automatic logic [9:0] frame_symbol(input logic k, input logic [7:0] d);
    return {^{k, d}, k, d};
  endfunction : frame_symbol

  // ---------------- Transmit clock domain ----------------
  logic tx_rst_n;
  logic tx_ack_sync;
  logic tx_allow_sync;
  logic [7:0] tx_byte;
  logic tx_took;
  logic [8:0] tx_word;
  logic tx_req;
  logic [7:0] next_tx_byte;
  logic next_tx_took;
  logic [8:0] next_tx_word;
  logic next_tx_req;
  logic tx_ack;
  logic tx_allow;

  sync_2ff #(.WIDTH(1)) u_tx_rst_sync (
    .clk(tx_clk),
    .rst_n(1'b1),
    .din(rst_n),
    .dout(tx_rst_n)
  );

  sync_2ff #(.WIDTH(2)) u_tx_ctl_sync (
    .clk(tx_clk),
    .rst_n(tx_rst_n),
    .din({tx_ack, tx_allow}),
    .dout({tx_ack_sync, tx_allow_sync})
  );

  // One byte is in flight at a time, so the crossing never overruns.
  assign tx_ready = tx_rst_n && tx_allow_sync && !tx_took && (tx_req == tx_ack_sync);

  always_comb begin
    next_tx_took = tx_data_valid && tx_ready;
    next_tx_byte = next_tx_took ? tx_data : tx_byte;
    if (!tx_rst_n) begin
      next_tx_took = 1'b0;
      next_tx_byte = 8'h00;
    end
  end

  always_ff @(posedge tx_clk) begin
    tx_took <= next_tx_took;
    tx_byte <= next_tx_byte;
  end

  // The falling edge carries the control flag that belongs to the byte just taken.
  always_comb begin
    next_tx_word = tx_word;
    next_tx_req = tx_req;
    if (!tx_rst_n) begin
      next_tx_word = 9'h000;
      next_tx_req = 1'b0;
    end else if (tx_took) begin
      next_tx_word = {tx_datak, tx_byte};
      next_tx_req = ~tx_req;
    end
  end

  always_ff @(negedge tx_clk) begin
    tx_word <= next_tx_word;
    tx_req <= next_tx_req;
  end

  // ---------------- System clock domain ----------------
  logic tx_req_sync;
  logic [1:0] pd_sync;
  logic lpbk_sync;
  logic common_sync;
  logic [9:0] rx_sym_sync;
  logic rx_sym_valid_sync;

  sync_2ff #(.WIDTH(5)) u_ctl_sync (
    .clk(clk_sys),
    .rst_n(rst_n),
    .din({tx_req, powerdown, loopback_req, common_clock}),
    .dout({tx_req_sync, pd_sync, lpbk_sync, common_sync})
  );

  sync_2ff #(.WIDTH(11)) u_rx_sync (
    .clk(clk_sys),
    .rst_n(rst_n),
    .din({ser_rx_sym_valid, ser_rx_sym}),
    .dout({rx_sym_valid_sync, rx_sym_sync})
  );

  // Transmit path: take the word on a request change and frame it.
  logic [10:0] tx_pipe_in;
  logic [10:0] tx_pipe_out;
  logic [9:0] next_ser_tx_sym;
  logic next_ser_tx_sym_valid;
  logic next_tx_ack;

  assign tx_pipe_in = {tx_req_sync != tx_ack, frame_symbol(tx_word[8], tx_word[7:0])};

  cycle_delay_line #(.WIDTH(11), .DEPTH(pipe_timing_pkg::TX_PIPE_CYC)) u_tx_pipe (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .din(tx_pipe_in),
    .dout(tx_pipe_out)
  );

  always_comb begin
    next_tx_ack = rst_n ? tx_req_sync : 1'b0;
    next_ser_tx_sym = tx_pipe_out[9:0];
    next_ser_tx_sym_valid = tx_pipe_out[10];
    if (lpbk_sync) begin
      next_ser_tx_sym = rx_sym_sync;
      next_ser_tx_sym_valid = rx_sym_valid_sync;
    end
    if (!rst_n) begin
      next_ser_tx_sym = 10'h000;
      next_ser_tx_sym_valid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    tx_ack <= next_tx_ack;
    ser_tx_sym <= next_ser_tx_sym;
    ser_tx_sym_valid <= next_ser_tx_sym_valid;
  end

  // Receive path: check the frame, delay it, launch it on the divided clock.
  logic rx_sym_err;
  logic [10:0] rx_pipe_out;
  logic [10:0] rx_prev;
  logic [10:0] next_rx_prev;
  logic [10:0] rx_slot;
  logic [7:0] next_rx_data;
  logic next_rx_datak;
  logic next_rx_data_valid;
  logic next_rx_decode_err;
  logic next_rx_clk;
  logic [2:0] rx_ctl_hold;
  logic [2:0] next_rx_ctl_hold;

  assign rx_sym_err = rx_sym_valid_sync &&
    (rx_sym_sync[pipe_timing_pkg::SYM_PAR_BIT] != ^rx_sym_sync[8:0]);

  cycle_delay_line #(.WIDTH(11), .DEPTH(pipe_timing_pkg::RX_PIPE_CYC)) u_rx_pipe (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .din({rx_sym_valid_sync, rx_sym_err, rx_sym_sync[8:0]}),
    .dout(rx_pipe_out)
  );

  // A symbol leaves the delay line for one cycle only, so each launch also looks one cycle back.
  assign rx_slot = rx_pipe_out[10] ? rx_pipe_out : rx_prev;

  // Data moves with the rising edge, its flags with the following falling edge.
  always_comb begin
    next_rx_clk = ~rx_clk;
    next_rx_data = rx_data;
    next_rx_ctl_hold = rx_ctl_hold;
    next_rx_datak = rx_datak;
    next_rx_data_valid = rx_data_valid;
    next_rx_decode_err = rx_decode_err;
    next_rx_prev = rst_n ? rx_pipe_out : 11'h000;
    if (!rx_clk) begin
      next_rx_data = rx_slot[10] ? rx_slot[7:0] : rx_data;
      next_rx_ctl_hold = rx_slot[10:8];
    end else begin
      next_rx_data_valid = rx_ctl_hold[2];
      next_rx_decode_err = rx_ctl_hold[1];
      next_rx_datak = rx_ctl_hold[0];
    end
    if (!rst_n) begin
      next_rx_clk = 1'b0;
      next_rx_data = 8'h00;
      next_rx_ctl_hold = 3'h0;
      next_rx_datak = 1'b0;
      next_rx_data_valid = 1'b0;
      next_rx_decode_err = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    rx_clk <= next_rx_clk;
    rx_data <= next_rx_data;
    rx_ctl_hold <= next_rx_ctl_hold;
    rx_prev <= next_rx_prev;
    rx_datak <= next_rx_datak;
    rx_data_valid <= next_rx_data_valid;
    rx_decode_err <= next_rx_decode_err;
  end

  // Receiver lock: counted fast-training sets or the lock timer, whichever first.
  pipe_timing_pkg::lock_state_e lock_state;
  pipe_timing_pkg::lock_state_e next_lock_state;
  logic [7:0] fts_count;
  logic [7:0] next_fts_count;
  logic [8:0] lock_timer;
  logic [8:0] next_lock_timer;
  logic prev_comma;
  logic next_prev_comma;
  logic [7:0] n_fts_need;
  logic rx_is_comma;
  logic rx_is_fts;

  assign n_fts_need = common_sync ? pipe_timing_pkg::N_FTS_COMMON
                                  : pipe_timing_pkg::N_FTS_SEPARATE;
  assign rx_is_comma = rx_sym_valid_sync && !rx_sym_err && rx_sym_sync[8]
                       && rx_sym_sync[7:0] == pipe_timing_pkg::SYM_COMMA;
  assign rx_is_fts = rx_sym_valid_sync && !rx_sym_err && rx_sym_sync[8]
                     && rx_sym_sync[7:0] == pipe_timing_pkg::SYM_FAST_TRAIN;

  always_comb begin
    next_lock_state = lock_state;
    next_fts_count = fts_count;
    next_lock_timer = lock_timer;
    next_prev_comma = rx_sym_valid_sync ? rx_is_comma : prev_comma;
    case (lock_state)
      pipe_timing_pkg::LK_IDLE: begin
        next_fts_count = 8'h00;
        next_lock_timer = 9'h000;
        if (rx_is_comma) begin
          next_lock_state = pipe_timing_pkg::LK_TRAIN;
        end
      end
      pipe_timing_pkg::LK_TRAIN: begin
        next_lock_timer = lock_timer + 9'h001;
        if (prev_comma && rx_is_fts) begin
          next_fts_count = fts_count + 8'h01;
        end
        if (next_fts_count == n_fts_need) begin
          next_lock_state = pipe_timing_pkg::LK_LOCKED;
        end
        if (lock_timer == 9'(pipe_timing_pkg::LOCK_NOM_CYC - 1)) begin
          next_lock_state = pipe_timing_pkg::LK_LOCKED;
        end
      end
      pipe_timing_pkg::LK_LOCKED: begin
        next_lock_timer = 9'h000;
      end
      default: begin
        next_lock_state = pipe_timing_pkg::LK_IDLE;
      end
    endcase
    // Lock is lost whenever the lane leaves the active state.
    if (!rst_n || pd_sync != pipe_timing_pkg::PD_P0) begin
      next_lock_state = pipe_timing_pkg::LK_IDLE;
      next_fts_count = 8'h00;
      next_lock_timer = 9'h000;
      next_prev_comma = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    lock_state <= next_lock_state;
    fts_count <= next_fts_count;
    lock_timer <= next_lock_timer;
    prev_comma <= next_prev_comma;
  end

  assign rx_locked = lock_state == pipe_timing_pkg::LK_LOCKED;
  assign n_fts_adv = n_fts_need;

  // Power state return and reset-to-ready sequencing of the ready indication.
  logic [1:0] pd_prev;
  logic [1:0] next_pd_prev;
  logic [3:0] pd_cnt;
  logic [3:0] next_pd_cnt;
  logic [3:0] rst_cnt;
  logic [3:0] next_rst_cnt;
  logic next_phy_ready_indication;
  logic next_tx_allow;
  logic pd_wake;

  assign pd_wake = pd_sync == pipe_timing_pkg::PD_P0 &&
                   (pd_prev == pipe_timing_pkg::PD_P0S || pd_prev == pipe_timing_pkg::PD_P1);

  always_comb begin
    next_pd_prev = pd_sync;
    next_pd_cnt = (pd_cnt != 4'h0) ? pd_cnt - 4'h1 : 4'h0;
    if (pd_wake) begin
      next_pd_cnt = 4'(pipe_timing_pkg::PD_WAKE_CYC);
    end
    next_rst_cnt = (rst_cnt != 4'h0) ? rst_cnt - 4'h1 : 4'h0;
    next_phy_ready_indication = (rst_cnt != 4'h0) || (pd_cnt == 4'h1);
    next_tx_allow = !next_phy_ready_indication && rst_cnt == 4'h0
                    && pd_sync == pipe_timing_pkg::PD_P0 && pd_cnt == 4'h0;
    if (!rst_n) begin
      next_pd_prev = pipe_timing_pkg::PD_P0;
      next_pd_cnt = 4'h0;
      next_rst_cnt = 4'(pipe_timing_pkg::RST_READY_CYC - 1);
      next_phy_ready_indication = 1'b1;
      next_tx_allow = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    pd_prev <= next_pd_prev;
    pd_cnt <= next_pd_cnt;
    rst_cnt <= next_rst_cnt;
    phy_ready_indication <= next_phy_ready_indication;
    tx_allow <= next_tx_allow;
  end

endmodule : pipe_phy_latency_power_timing

// file: test/pipe_timing_sva.sv
module pipe_timing_sva (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Watched ports
  input wire logic [1:0] powerdown,
  input wire logic common_clock,
  input wire logic loopback_req,
  input wire logic phy_ready_indication,
  input wire logic rx_clk,
  input wire logic [7:0] rx_data,
  input wire logic rx_data_valid,
  input wire logic [7:0] n_fts_adv,
  input wire logic [9:0] ser_tx_sym,
  input wire logic ser_tx_sym_valid,
  input wire logic ser_rx_sym_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_rst_ready;
    rst_n && !$past(rst_n) |=> !phy_ready_indication;
  endproperty
  a_rst_ready: assert property (p_rst_ready)
    else $error("ready indication still high after reset release");
  property p_wake_p0s;
    powerdown == pipe_timing_pkg::PD_P0 && $past(powerdown) == pipe_timing_pkg::PD_P0S
      |-> ##[1:6] phy_ready_indication;
  endproperty
  a_wake_p0s: assert property (p_wake_p0s)
    else $error("no ready indication after leaving P0s");
  property p_wake_p1;
    powerdown == pipe_timing_pkg::PD_P0 && $past(powerdown) == pipe_timing_pkg::PD_P1
      |-> ##[1:6] phy_ready_indication;
  endproperty
  a_wake_p1: assert property (p_wake_p1)
    else $error("no ready indication after leaving P1");
  // Five cycles leave room for the input synchroniser on the clock-mode pin.
  property p_nfts_common;
    (common_clock && rst_n)[*5] |-> n_fts_adv == pipe_timing_pkg::N_FTS_COMMON;
  endproperty
  a_nfts_common: assert property (p_nfts_common)
    else $error("wrong training set count with common clock");
  property p_nfts_separate;
    (!common_clock && rst_n)[*5] |-> n_fts_adv == pipe_timing_pkg::N_FTS_SEPARATE;
  endproperty
  a_nfts_separate: assert property (p_nfts_separate)
    else $error("wrong training set count without common clock");
  property p_tx_parity;
    ser_tx_sym_valid |-> ser_tx_sym[9] == ^ser_tx_sym[8:0];
  endproperty
  a_tx_parity: assert property (p_tx_parity)
    else $error("transmit symbol framing broken");
  property p_rx_latency;
    $rose(ser_rx_sym_valid) |-> ##[6:14] rx_data_valid;
  endproperty
  a_rx_latency: assert property (p_rx_latency)
    else $error("received byte late or missing");
  property p_rx_clk;
    $past(rst_n) |-> rx_clk != $past(rx_clk);
  endproperty
  a_rx_clk: assert property (p_rx_clk)
    else $error("receive clock not toggling");
  property p_rx_launch;
    $past(rst_n) && rx_data != $past(rx_data) |-> rx_clk && !$past(rx_clk);
  endproperty
  a_rx_launch: assert property (p_rx_launch)
    else $error("receive data changed away from a rising receive clock");
  property p_loopback;
    loopback_req[*4] ##0 $rose(ser_rx_sym_valid) |-> ##[1:6] ser_tx_sym_valid;
  endproperty
  a_loopback: assert property (p_loopback)
    else $error("looped symbol not retransmitted in time");
endmodule : pipe_timing_sva

bind pipe_phy_latency_power_timing pipe_timing_sva u_sva (.clk_sys, .rst_n, .powerdown,
  .common_clock, .loopback_req, .phy_ready_indication, .rx_clk, .rx_data, .rx_data_valid,
  .n_fts_adv, .ser_tx_sym, .ser_tx_sym_valid, .ser_rx_sym_valid);

// file: test/mac_model.sv
module mac_model (
  // Transmit clock and data to the device
  output logic tx_clk,
  output logic [7:0] tx_data,
  output logic tx_data_valid,
  output logic tx_datak,
  // Acceptance from the device
  input wire logic tx_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    tx_clk = 1'b0;
    tx_data = 8'h00;
    tx_data_valid = 1'b0;
    tx_datak = 1'b0;
    forever #3 tx_clk = ~tx_clk;
  end
  // The byte is held until a rising edge sees the device ready; the flag
  // waits for the falling edge that samples it, then both lines scramble.
  task automatic send(input logic [7:0] b, input logic k);
    int n;
    n = 0;
    @(posedge tx_clk);
    tx_data <= b;
    tx_datak <= k;
    tx_data_valid <= 1'b1;
    @(posedge tx_clk);
    while (tx_ready !== 1'b1 && n < 200) begin
      n++;
      @(posedge tx_clk);
    end
    tx_data_valid <= 1'b0;
    @(negedge tx_clk);
    tx_data <= ~b;
    tx_datak <= ~k;
  endtask : send
endmodule : mac_model

// file: test/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, rst_n, tx_clk, tx_data_valid, tx_datak, tx_ready, rx_clk, rx_datak;
  logic rx_data_valid, rx_decode_err, loopback_req, common_clock, phy_ready_indication;
  logic rx_locked, ser_tx_sym_valid, ser_rx_sym_valid, seen;
  logic [7:0] tx_data, rx_data, n_fts_adv;
  logic [1:0] powerdown;
  logic [9:0] ser_tx_sym, ser_rx_sym;
  logic [3:0] ev;
  int miscompares = 0;
  int samples_checked = 0;
  pipe_phy_latency_power_timing dut (.clk_sys, .rst_n, .tx_clk, .tx_data, .tx_data_valid,
    .tx_datak, .tx_ready, .rx_clk, .rx_data, .rx_datak, .rx_data_valid, .rx_decode_err,
    .powerdown, .loopback_req, .common_clock, .phy_ready_indication, .rx_locked, .n_fts_adv,
    .ser_tx_sym, .ser_tx_sym_valid, .ser_rx_sym, .ser_rx_sym_valid);
  mac_model mac (.tx_clk, .tx_data, .tx_data_valid, .tx_datak, .tx_ready);
  assign ev = {phy_ready_indication, ser_tx_sym_valid, rx_data_valid | rx_decode_err, rx_locked};
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task stop_test;
    $display("checked %0d, miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  task check_bits(input logic [9:0] got, input logic [9:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_bits
  task check_seen(input logic got);
    check_bits({9'h000, got}, 10'h001);
  endtask : check_seen
  task wait_ev(input int i, input int lim, output logic hit);
    hit = 1'b0;
    repeat (lim) begin
      @(posedge clk_sys);
      if (ev[i] === 1'b1) begin
        hit = 1'b1;
        break;
      end
    end
  endtask : wait_ev
  function automatic logic [9:0] mk(input logic k, input logic [7:0] b);
    return {^{k, b}, k, b};
  endfunction : mk
  // A released symbol line shows the inverse, so stale data never looks valid.
  task send_rx(input logic [9:0] s);
    ser_rx_sym <= s;
    ser_rx_sym_valid <= 1'b1;
    @(posedge clk_sys);
    ser_rx_sym <= ~s;
    ser_rx_sym_valid <= 1'b0;
    @(posedge clk_sys);
  endtask : send_rx
  task t_reset;
    repeat (3) @(posedge clk_sys);
    check_bits(phy_ready_indication, 10'h001);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1 check_bits(phy_ready_indication, 10'h000);
    @(posedge clk_sys);
  endtask : t_reset
  task t_nfts;
    for (int v = 0; v < 2; v++) begin
      common_clock <= v[0];
      repeat (6) @(posedge clk_sys);
      check_bits(n_fts_adv, v ? 10'h017 : 10'h0ff);
    end
  endtask : t_nfts
  task t_tx;
    for (int i = 0; i < 2; i++) begin
      mac.send(i ? 8'hbc : 8'ha5, i[0]);
      wait_ev(2, 12, seen);
      check_seen(seen);
      check_bits(ser_tx_sym, mk(i[0], i ? 8'hbc : 8'ha5));
    end
  endtask : t_tx
  task automatic t_rx;
    logic [9:0] s [3];
    s = '{mk(1'b0, 8'h5a), mk(1'b1, 8'hf7), mk(1'b0, 8'h5a) ^ 10'h200};
    for (int i = 0; i < 3; i++) begin
      fork
        send_rx(s[i]);
        wait_ev(1, 18, seen);
      join
      check_seen(seen);
      check_bits(rx_decode_err, i == 2);
      if (i < 2) check_bits({rx_datak, rx_data}, s[i][8:0]);
      repeat (4) @(posedge clk_sys);
    end
  endtask : t_rx
  task t_loop;
    loopback_req <= 1'b1;
    repeat (4) @(posedge clk_sys);
    fork
      send_rx(mk(1'b0, 8'h96));
      wait_ev(2, 10, seen);
    join
    check_seen(seen);
    check_bits(ser_tx_sym, mk(1'b0, 8'h96));
    loopback_req <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : t_loop
  task t_lock;
    check_bits(rx_locked, 10'h000);
    repeat (22) begin
      send_rx(mk(1'b1, pipe_timing_pkg::SYM_COMMA));
      send_rx(mk(1'b1, pipe_timing_pkg::SYM_FAST_TRAIN));
    end
    repeat (12) @(posedge clk_sys);
    check_bits(rx_locked, 10'h000);
    send_rx(mk(1'b1, pipe_timing_pkg::SYM_COMMA));
    send_rx(mk(1'b1, pipe_timing_pkg::SYM_FAST_TRAIN));
    wait_ev(0, 20, seen);
    check_seen(seen);
  endtask : t_lock
  task t_wake;
    for (int i = 0; i < 2; i++) begin
      powerdown <= i ? pipe_timing_pkg::PD_P1 : pipe_timing_pkg::PD_P0S;
      repeat (8) @(posedge clk_sys);
      check_bits(tx_ready, 10'h000);
      powerdown <= pipe_timing_pkg::PD_P0;
      wait_ev(3, 6, seen);
      check_seen(seen);
      repeat (4) @(posedge clk_sys);
      check_bits(tx_ready, 10'h001);
    end
  endtask : t_wake
  task t_lock_timer;
    check_bits(rx_locked, 10'h000);
    send_rx(mk(1'b1, pipe_timing_pkg::SYM_COMMA));
    wait_ev(0, pipe_timing_pkg::LOCK_MAX_CYC, seen);
    check_seen(seen);
  endtask : t_lock_timer
  initial begin
    rst_n = 1'b0;
    powerdown = pipe_timing_pkg::PD_P0;
    loopback_req = 1'b0;
    common_clock = 1'b0;
    ser_rx_sym = 10'h000;
    ser_rx_sym_valid = 1'b0;
    t_reset();
    t_nfts();
    t_tx();
    t_rx();
    t_loop();
    t_lock();
    t_wake();
    t_lock_timer();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    stop_test();
  end
endmodule : testbench
